// [verilog/frontend_mode_control.v]
// Operating mode and RF front-end control for an NFC reader
// Assumes one clock, register port from a serial host bridge,
// analog status and modulation strobes synchronous to core_clk
//
// Summary of operation
// - Reset clears operation control; block rests in power-down, regulators off.
// - Power-down keeps register access; memory and FIFO access refused.
// - Enable bit 7 starts oscillator, regulators, tuning; ready mode; memory open.
// - In ready mode, interrupt once oscillator becomes stable.
// - Receiver and transmitter have independent enable bits.
// - Wake-up bit alone gives wake-up mode with RC oscillator and timer.
// - Wake-up measurement differing from reference raises interrupt.
// - Single driver mode uses one driver; select bit picks output and input.
// - Eight binary segments; resistance field picks conducting segments.
// - Resistance field resets to lowest output resistance.
// - Modulation type bit selects AM or OOK.
// - OOK modulated state stops carrier drive.
// - AM modulated state supplies drivers from AM regulator at level field.
// - Internal and external load modulation chosen separately, both allowed.
// - With extracted clock, unmodulated impedance outside modulation, modulated during it; held otherwise.
// - External load modulation drives modulation pin with load signal.
// - Polarity bit inverts external modulation pin.
// - Receiver powered only while receiver enable bit is 1.
// - Channel: both bits 0 automatic; else select bit, 0 AM/I, 1 PM/Q.
// - In automatic mode receiver logic picks channel feeding framing.
//
// Added by the designer: the placing of the registers and strobed register access.
`include "frontend_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module frontend_mode_control #(
  parameter WAKE_PRESCALE = 16'd1000
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Analog status and transfer strobes
  input wire osc_stable,
  input wire tx_modulate,
  input wire target_mode,
  input wire extracted_clk_ok,
  input wire loadmod_signal,
  input wire wake_difference,
  input wire am_activity,
  input wire pm_activity,
  // Power and clock controls
  output reg osc_enable,
  output reg regulator_enable,
  output reg antenna_tuning,
  output reg rc_osc_enable,
  output reg wakeup_measure,
  output wire mem_access_ok,
  output wire irq,
  // Transmitter
  output reg [7:0] antenna_driver_a,
  output reg [7:0] antenna_driver_b,
  output reg am_supply_select,
  output reg [3:0] am_level_field,
  output reg external_modulation_gate,
  // Receiver
  output reg receiver_power,
  output reg receive_input_b,
  output reg channel_choice
);

  // ************************************************************
  // Functions
  // ************************************************************
  // Resistance code to conducting segment mask
  function [7:0] seg_mask;
    input [3:0] res;
    reg [3:0] off;
    begin
      off = (res > `MAX_OFF) ? `MAX_OFF : res;
      seg_mask = 8'hFF >> off;
    end
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  reg [7:0] op_ctrl_reg;
  reg [7:0] io_cfg_reg;
  reg [7:0] mode_def_reg;
  reg [7:0] tx_drv_reg;
  reg [7:0] lm_imp_reg;
  reg [7:0] lm_cfg_reg;
  reg [7:0] wake_period_reg;
  reg [1:0] irq_flags_reg;
  reg [1:0] mode_reg;
  reg [1:0] mode_next;
  reg osc_seen_reg;
  reg [15:0] pre_cnt_reg;
  reg [7:0] wake_cnt_reg;
  reg [3:0] lm_imp_applied_reg;
  reg auto_chan_reg;
  reg [7:0] status_word;

  // ************************************************************
  // Field decode
  // ************************************************************
  wire en_bit = op_ctrl_reg[`OP_EN];
  wire rx_en_bit = op_ctrl_reg[`OP_RX_EN];
  wire tx_en_bit = op_ctrl_reg[`OP_TX_EN];
  wire rx_chn_bit = op_ctrl_reg[`OP_RX_CHN];
  wire rx_man_bit = op_ctrl_reg[`OP_RX_MAN];
  wire single_bit = io_cfg_reg[`IO_SINGLE];
  wire second_output_select = io_cfg_reg[`IO_SECOND];
  wire modulation_type_select = mode_def_reg[`MODE_AM];
  wire internal_loadmod_select = lm_cfg_reg[`LM_INT];
  wire external_loadmod_select = lm_cfg_reg[`LM_EXT];
  wire external_loadmod_invert = lm_cfg_reg[`LM_POL];
  wire manual_channel = lm_cfg_reg[`LM_CHAN];
  wire [3:0] unmodulated_impedance = lm_imp_reg[`IMP_UN_HI:`IMP_UN_LO];
  wire [3:0] modulated_impedance = lm_imp_reg[`IMP_MOD_HI:`IMP_MOD_LO];
  wire [3:0] normal_resistance = tx_drv_reg[`TXD_RES_HI:`TXD_RES_LO];
  wire [3:0] am_level_next = tx_drv_reg[`TXD_AML_HI:`TXD_AML_LO];
  wire rd_status = reg_rd && (reg_addr == `A_STATUS);
  wire wake_only = (op_ctrl_reg == `OP_WAKE_ALONE);
  wire in_ready = (mode_reg == `MD_READY);
  wire in_wake = (mode_reg == `MD_WAKE);
  wire pre_wrap = (pre_cnt_reg >= WAKE_PRESCALE - 16'd1);
  wire period_done = (wake_cnt_reg >= wake_period_reg);

  // Status word: mode field and sticky flags
  always @* begin
    status_word = 8'h00;
    status_word[`ST_MODE_LO +: 2] = mode_reg;
    status_word[`ST_OSC] = irq_flags_reg[`ST_OSC];
    status_word[`ST_WAKE] = irq_flags_reg[`ST_WAKE];
  end

  // ************************************************************
  // Register writes
  // ************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      op_ctrl_reg <= `RST_OP;
      io_cfg_reg <= `RST_IO;
      mode_def_reg <= `RST_MODE;
      tx_drv_reg <= `RST_TXD;
      lm_imp_reg <= `RST_LMI;
      lm_cfg_reg <= `RST_LMC;
      wake_period_reg <= `RST_WAKE;
    end else if (reg_wr) begin
      // Configuration stays writable in every mode
      case (reg_addr)
        `A_OP_CTRL: op_ctrl_reg <= reg_wdata;
        `A_IO_CFG: io_cfg_reg <= reg_wdata;
        `A_MODE: mode_def_reg <= reg_wdata;
        `A_TX_DRV: tx_drv_reg <= reg_wdata;
        `A_LM_IMP: lm_imp_reg <= reg_wdata;
        `A_LM_CFG: lm_cfg_reg <= reg_wdata;
        `A_WAKE_TMR: wake_period_reg <= reg_wdata;
        default: op_ctrl_reg <= op_ctrl_reg;
      endcase
    end
  end

  // ************************************************************
  // Register reads
  // ************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `A_OP_CTRL: reg_rdata <= op_ctrl_reg;
        `A_IO_CFG: reg_rdata <= io_cfg_reg;
        `A_MODE: reg_rdata <= mode_def_reg;
        `A_TX_DRV: reg_rdata <= tx_drv_reg;
        `A_LM_IMP: reg_rdata <= lm_imp_reg;
        `A_LM_CFG: reg_rdata <= lm_cfg_reg;
        `A_WAKE_TMR: reg_rdata <= wake_period_reg;
        `A_STATUS: reg_rdata <= status_word;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ************************************************************
  // Operating mode
  // ************************************************************
  always @* begin
    if (en_bit) begin
      mode_next = `MD_READY;
    end else if (wake_only) begin
      mode_next = `MD_WAKE;
    end else if (op_ctrl_reg == `RST_OP) begin
      mode_next = `MD_PDOWN;
    end else begin
      mode_next = `MD_OTHER;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= `MD_PDOWN;
      osc_enable <= 1'b0;
      regulator_enable <= 1'b0;
      antenna_tuning <= 1'b0;
      rc_osc_enable <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      osc_enable <= en_bit;
      regulator_enable <= en_bit;
      antenna_tuning <= en_bit;
      rc_osc_enable <= wake_only;
    end
  end

  // Memory and FIFO open only when enabled
  assign mem_access_ok = in_ready;

  // ************************************************************
  // Wake-up timer
  // ************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pre_cnt_reg <= 16'h0000;
      wake_cnt_reg <= 8'h00;
      wakeup_measure <= 1'b0;
    end else if (!in_wake || !wake_only) begin
      // Leaving wake-up stops the timer at once
      pre_cnt_reg <= 16'h0000;
      wake_cnt_reg <= 8'h00;
      wakeup_measure <= 1'b0;
    end else begin
      wakeup_measure <= 1'b0;
      if (pre_wrap) begin
        pre_cnt_reg <= 16'h0000;
        if (period_done) begin
          wake_cnt_reg <= 8'h00;
          wakeup_measure <= 1'b1;
        end else begin
          wake_cnt_reg <= wake_cnt_reg + 8'h01;
        end
      end else begin
        pre_cnt_reg <= pre_cnt_reg + 16'h0001;
      end
    end
  end

  // ************************************************************
  // Interrupt flags, cleared on status read, set wins
  // ************************************************************
  wire osc_event = in_ready && osc_stable && !osc_seen_reg;
  wire wake_event = in_wake && wake_difference;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_flags_reg <= 2'h0;
      osc_seen_reg <= 1'b0;
    end else begin
      osc_seen_reg <= in_ready && (osc_seen_reg || osc_stable);
      irq_flags_reg[`ST_OSC] <= osc_event ||
        (irq_flags_reg[`ST_OSC] && !rd_status);
      irq_flags_reg[`ST_WAKE] <= wake_event ||
        (irq_flags_reg[`ST_WAKE] && !rd_status);
    end
  end

  assign irq = |irq_flags_reg;

  // ************************************************************
  // Load modulation impedance, applied with extracted clock
  // ************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lm_imp_applied_reg <= 4'h0;
    end else if (extracted_clk_ok) begin
      lm_imp_applied_reg <= tx_modulate ? modulated_impedance :
                            unmodulated_impedance;
    end
  end

  // ************************************************************
  // Transmitter drive
  // ************************************************************
  wire tx_on = en_bit && tx_en_bit;
  wire ook_gap = tx_modulate && !modulation_type_select;
  wire drv_lm = target_mode && internal_loadmod_select;
  wire [7:0] tx_seg = seg_mask(normal_resistance);
  wire [7:0] lm_seg = seg_mask(lm_imp_applied_reg);
  reg [7:0] seg_next;

  always @* begin
    if (drv_lm) begin
      seg_next = lm_seg;
    end else if (tx_on && !ook_gap) begin
      seg_next = tx_seg;
    end else begin
      seg_next = 8'h00;
    end
  end

  // ************************************************************
  // Driver selection and external pin
  // ************************************************************
  reg [7:0] drv_a_next;
  reg [7:0] drv_b_next;

  // Single mode keeps only the selected driver
  always @* begin
    drv_a_next = seg_next;
    drv_b_next = seg_next;
    if (single_bit) begin
      if (second_output_select) begin
        drv_a_next = 8'h00;
      end else begin
        drv_b_next = 8'h00;
      end
    end
  end

  // Pin level before target gating
  wire ext_pin_level = loadmod_signal ^ external_loadmod_invert;
  wire ext_gate_next = target_mode && external_loadmod_select && ext_pin_level;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      antenna_driver_a <= 8'h00;
      antenna_driver_b <= 8'h00;
      am_supply_select <= 1'b0;
      am_level_field <= 4'h0;
      external_modulation_gate <= 1'b0;
    end else begin
      antenna_driver_a <= drv_a_next;
      antenna_driver_b <= drv_b_next;
      am_supply_select <= tx_on && tx_modulate && modulation_type_select;
      am_level_field <= am_level_next;
      external_modulation_gate <= ext_gate_next;
    end
  end

  // ************************************************************
  // Receiver power and channel choice
  // ************************************************************
  wire auto_sel = !rx_chn_bit && !rx_man_bit;
  wire rx_on = rx_en_bit && en_bit;
  reg auto_chan_next;

  // Last channel with exclusive activity wins framing
  always @* begin
    auto_chan_next = auto_chan_reg;
    if (am_activity && !pm_activity) begin
      auto_chan_next = 1'b0;
    end else if (pm_activity && !am_activity) begin
      auto_chan_next = 1'b1;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      auto_chan_reg <= 1'b0;
      receiver_power <= 1'b0;
      receive_input_b <= 1'b0;
      channel_choice <= 1'b0;
    end else begin
      auto_chan_reg <= auto_chan_next;
      receiver_power <= rx_on;
      receive_input_b <= single_bit && second_output_select;
      channel_choice <= auto_sel ? auto_chan_reg : manual_channel;
    end
  end

endmodule // frontend_mode_control

`default_nettype wire

// [verilog/frontend_consts.vh]
// Constants for the front-end mode control block
// Included by frontend_mode_control.v; definitions only
`ifndef FRONTEND_CONSTS_VH
`define FRONTEND_CONSTS_VH

// Register offsets
`define A_OP_CTRL 3'h0
`define A_IO_CFG 3'h1
`define A_MODE 3'h2
`define A_TX_DRV 3'h3
`define A_LM_IMP 3'h4
`define A_LM_CFG 3'h5
`define A_WAKE_TMR 3'h6
`define A_STATUS 3'h7

// Operation control fields
`define OP_EN 7
`define OP_RX_EN 6
`define OP_RX_CHN 5
`define OP_RX_MAN 4
`define OP_TX_EN 3
`define OP_WAKE 2
`define OP_WAKE_ALONE 8'h04

// Other field positions
`define IO_SINGLE 0
`define IO_SECOND 1
`define MODE_AM 0
`define LM_INT 0
`define LM_EXT 1
`define LM_POL 2
`define LM_CHAN 3
`define TXD_RES_HI 3
`define TXD_RES_LO 0
`define TXD_AML_HI 7
`define TXD_AML_LO 4
`define IMP_UN_HI 3
`define IMP_UN_LO 0
`define IMP_MOD_HI 7
`define IMP_MOD_LO 4

// Reset values
`define RST_OP 8'h00
`define RST_IO 8'h00
`define RST_MODE 8'h00
`define RST_TXD 8'h00
`define RST_LMI 8'h00
`define RST_LMC 8'h00
`define RST_WAKE 8'h10

// Mode state codes
`define MD_PDOWN 2'h0
`define MD_READY 2'h1
`define MD_WAKE 2'h2
`define MD_OTHER 2'h3

// Status bits
`define ST_OSC 0
`define ST_WAKE 1
`define ST_MODE_LO 4

// Largest segments switched off
`define MAX_OFF 4'h7

`endif

// [verilog/unused_placeholder_none.v]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [testbench/osc_model.sv]
// Oscillator model standing beside the front-end control block
// Assumes osc_enable from the block, clock core_clk
`timescale 1ns/1ps
`default_nettype none
module osc_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Oscillator
  input wire logic osc_enable,
  output logic osc_stable
);
  logic [2:0] cnt_reg;
  // Settles seven cycles after enable, drops at once when disabled
  always @(posedge core_clk or posedge rst) begin
    if (rst) cnt_reg <= 3'h0;
    else if (!osc_enable) cnt_reg <= 3'h0;
    else if (cnt_reg != 3'h7) cnt_reg <= cnt_reg + 3'h1;
  end
  assign osc_stable = (cnt_reg == 3'h7);
endmodule // osc_model
`default_nettype wire

// [testbench/frontend_mode_control_properties.sv]
// Port checker for the front-end mode control block
// Assumes bind onto frontend_mode_control
`timescale 1ns/1ps
`default_nettype none
module frontend_mode_control_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Watched ports
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic osc_stable,
  input wire logic target_mode,
  input wire logic wake_difference,
  input wire logic osc_enable,
  input wire logic regulator_enable,
  input wire logic antenna_tuning,
  input wire logic rc_osc_enable,
  input wire logic wakeup_measure,
  input wire logic mem_access_ok,
  input wire logic irq,
  input wire logic [7:0] antenna_driver_a,
  input wire logic receive_input_b,
  input wire logic receiver_power,
  input wire logic external_modulation_gate
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_rdata_after_read: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
    else $error("read data outside read slot");
  chk_enable_group: assert property (regulator_enable == osc_enable && antenna_tuning == osc_enable)
    else $error("enable outputs disagree");
  chk_mem_when_ready: assert property (mem_access_ok |-> osc_enable && !rc_osc_enable)
    else $error("memory open outside ready");
  chk_osc_irq: assert property ($rose(osc_stable) && mem_access_ok |-> ##[1:2] irq)
    else $error("no interrupt on oscillator stable");
  chk_rx_power: assert property (receiver_power |-> osc_enable)
    else $error("receiver powered while disabled");
  chk_wake_alone: assert property (rc_osc_enable |-> !osc_enable && !receiver_power)
    else $error("wake-up mode with other bits");
  chk_wake_pulse: assert property (wakeup_measure |-> rc_osc_enable ##1 !wakeup_measure)
    else $error("bad wake-up measure pulse");
  chk_wake_irq: assert property (wake_difference && rc_osc_enable |-> ##[1:2] irq)
    else $error("no interrupt on wake difference");
  chk_single_b: assert property (receive_input_b |-> antenna_driver_a == 8'h00)
    else $error("first driver active with second selected");
  chk_ext_gate: assert property (external_modulation_gate |-> $past(target_mode))
    else $error("external gate outside target mode");
endmodule // frontend_mode_control_chk
bind frontend_mode_control frontend_mode_control_chk u_chk (.core_clk, .rst, .reg_rd, .reg_rdata,
  .osc_stable, .target_mode, .wake_difference, .osc_enable, .regulator_enable, .antenna_tuning,
  .rc_osc_enable, .wakeup_measure, .mem_access_ok, .irq, .antenna_driver_a, .receive_input_b,
  .receiver_power, .external_modulation_gate);
`default_nettype wire

// [testbench/frontend_mode_control_tb.sv]
// Self-checking bench for the front-end mode control block
// Assumes frontend_consts.vh on the include path
`include "frontend_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module frontend_mode_control_tb;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [2:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, antenna_driver_a, antenna_driver_b, flags;
  logic tx_modulate = 0, target_mode = 0, extracted_clk_ok = 0, loadmod_signal = 0;
  logic wake_difference = 0, am_activity = 0, pm_activity = 0, osc_stable, osc_enable;
  logic regulator_enable, antenna_tuning, rc_osc_enable, wakeup_measure, mem_access_ok, irq;
  logic am_supply_select, external_modulation_gate, receiver_power, receive_input_b;
  logic channel_choice, ls, e;
  logic [1:0] lm;
  logic [3:0] am_level_field, c, l;
  integer seed, n_fail = 0, checks = 0, i, n;
  assign flags = {osc_enable, regulator_enable, antenna_tuning, mem_access_ok, receiver_power,
    rc_osc_enable, receive_input_b, channel_choice};
  frontend_mode_control #(.WAKE_PRESCALE(16'd2)) dut (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .osc_stable(osc_stable), .tx_modulate(tx_modulate),
    .target_mode(target_mode), .extracted_clk_ok(extracted_clk_ok),
    .loadmod_signal(loadmod_signal), .wake_difference(wake_difference),
    .am_activity(am_activity), .pm_activity(pm_activity), .osc_enable(osc_enable),
    .regulator_enable(regulator_enable), .antenna_tuning(antenna_tuning),
    .rc_osc_enable(rc_osc_enable), .wakeup_measure(wakeup_measure),
    .mem_access_ok(mem_access_ok), .irq(irq), .antenna_driver_a(antenna_driver_a),
    .antenna_driver_b(antenna_driver_b), .am_supply_select(am_supply_select),
    .am_level_field(am_level_field), .external_modulation_gate(external_modulation_gate),
    .receiver_power(receiver_power), .receive_input_b(receive_input_b),
    .channel_choice(channel_choice));
  osc_model osc (.core_clk(core_clk), .rst(rst), .osc_enable(osc_enable),
    .osc_stable(osc_stable));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [7:0] mask(input logic [3:0] code);
    return 8'hFF >> ((code > 4'h7) ? 4'h7 : code);
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task stop_test;
    $display("Counts: checks=%0d fails=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    stop_test;
  end
  initial begin
    seed = 32'hc93f0356;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(`A_OP_CTRL, `RST_OP);
    rd(`A_TX_DRV, `RST_TXD);
    rd(`A_WAKE_TMR, `RST_WAKE);
    chk(flags, 8'h00);
    wr(`A_LM_IMP, 8'h5A);
    rd(`A_LM_IMP, 8'h5A);
    wr(`A_LM_IMP, 8'h30);
    $display("Reset test done");
    wr(`A_OP_CTRL, 8'h88);
    settle;
    chk(flags, 8'hF0);
    chk(antenna_driver_a, 8'hFF);
    n = 0;
    while (!irq && n < 30) begin
      @(posedge core_clk);
      n++;
    end
    rd(`A_STATUS, 8'h11);
    rd(`A_STATUS, 8'h10);
    for (i = 0; i < 10; i++) begin
      c = (i == 0) ? 4'hF : $random(seed);
      l = $random(seed);
      wr(`A_TX_DRV, {l, c});
      settle;
      chk(antenna_driver_a, mask(c));
      chk({4'h0, am_level_field}, {4'h0, l});
    end
    wr(`A_TX_DRV, 8'h00);
    wr(`A_MODE, 8'h00);
    tx_modulate <= 1'b1;
    settle;
    chk(antenna_driver_a, 8'h00);
    wr(`A_MODE, 8'h01);
    settle;
    chk({7'h00, am_supply_select}, 8'h01);
    chk(antenna_driver_a, 8'hFF);
    tx_modulate <= 1'b0;
    wr(`A_IO_CFG, 8'h01);
    settle;
    chk(antenna_driver_b, 8'h00);
    wr(`A_IO_CFG, 8'h03);
    settle;
    chk({antenna_driver_b, flags} == {8'hFF, 8'hF2}, 1'b1);
    wr(`A_IO_CFG, 8'h00);
    wr(`A_OP_CTRL, 8'hC0);
    settle;
    chk(flags, 8'hF8);
    chk(antenna_driver_a, 8'h00);
    $display("Transmit test done");
    for (i = 0; i < 8; i++) begin
      wr(`A_LM_CFG, {4'h0, i[0], 3'h0});
      wr(`A_OP_CTRL, {2'b11, i[2:1], 4'h0});
      settle;
      chk({7'h00, channel_choice}, {7'h00, (i[2:1] == 2'b00) ? 1'b0 : i[0]});
    end
    wr(`A_OP_CTRL, 8'hC0);
    pm_activity <= 1'b1;
    @(posedge core_clk);
    pm_activity <= 1'b0;
    settle;
    chk({7'h00, channel_choice}, 8'h01);
    am_activity <= 1'b1;
    @(posedge core_clk);
    am_activity <= 1'b0;
    settle;
    chk({7'h00, channel_choice}, 8'h00);
    $display("Receive test done");
    wr(`A_OP_CTRL, 8'h88);
    target_mode <= 1'b1;
    for (i = 0; i < 32; i++) begin
      lm = i[4:3] + 2'h1;
      if (i % 8 == 0) wr(`A_LM_CFG, {5'h00, lm, i[4]});
      ls = $random(seed);
      e = (ls ^ lm[1]) & lm[0];
      @(posedge core_clk);
      loadmod_signal <= ls;
      @(posedge core_clk);
      #1 chk({7'h00, external_modulation_gate}, {7'h00, e});
    end
    wr(`A_LM_CFG, 8'h01);
    tx_modulate <= 1'b1;
    settle;
    chk(antenna_driver_a, 8'hFF);
    extracted_clk_ok <= 1'b1;
    settle;
    chk(antenna_driver_a, 8'h1F);
    tx_modulate <= 1'b0;
    settle;
    chk(antenna_driver_a, 8'hFF);
    target_mode <= 1'b0;
    $display("Load modulation test done");
    wr(`A_WAKE_TMR, 8'h01);
    wr(`A_OP_CTRL, 8'h04);
    settle;
    chk(flags, 8'h04);
    n = 0;
    repeat (40) begin
      @(posedge core_clk);
      #1 n = n + wakeup_measure;
    end
    chk({7'h00, n >= 9 && n <= 11}, 8'h01);
    wake_difference <= 1'b1;
    @(posedge core_clk);
    wake_difference <= 1'b0;
    settle;
    chk({7'h00, irq}, 8'h01);
    rd(`A_STATUS, 8'h22);
    $display("Wake-up test done");
    stop_test;
  end
endmodule // frontend_mode_control_tb
`default_nettype wire
